// file: hw/apr_bank.v
`include "apr_map.vh"
// four-word active-priority bank, one copy per group/security view
module apr_bank (
	input wire mclk_i,
	input wire resetn_i,
	input wire wr_i,
	input wire [1:0] idx_i,
	input wire [31:0] wdata_i,
	output wire [31:0] rdata_o
);
	wire [31:0] word_w [0:3];
	genvar g;
	// each word is whole-replaced on write, zero after reset
	// one register per generate block keeps every word to a single driver
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_word
			localparam [1:0] WORD_IDX = g;
			reg [31:0] word_r;
			always @(posedge mclk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					word_r <= `APR_RESET_VAL;
				end else if (wr_i && (idx_i == WORD_IDX)) begin
					word_r <= wdata_i;
				end
			end
			assign word_w[g] = word_r;
		end
	endgenerate
	assign rdata_o = word_w[idx_i];
endmodule

// file: hw/apr_map.vh
`ifndef APR_MAP_VH
`define APR_MAP_VH
// system register encoding fields
`define APR_CRN_VAL 4'hC
`define APR_CRM_G0 4'h8
`define APR_CRM_G1 4'h9
`define APR_OPC1_VAL 3'h0
`define APR_OP2_G0_PFX 1'h1
`define APR_OP2_G1_PFX 1'h0
`define APR_OP2_PFX_BIT 2
// reset value of every active-priority word
`define APR_RESET_VAL 32'h00000000
// priority-bit thresholds for implemented indices
`define APR_PRI_IDX1 3'h6
`define APR_PRI_IDX2 3'h7
// exception level encodings
`define APR_EL0 2'h0
`define APR_EL1 2'h1
`define APR_EL2 2'h2
`define APR_EL3 2'h3
// result codes
`define APR_RES_OK 3'h0
`define APR_RES_VIRT 3'h1
`define APR_RES_TRAP_EL2 3'h2
`define APR_RES_TRAP_EL3 3'h3
`define APR_RES_UNDEF 3'h4
`endif

// file: hw/apr_regs.v
// Overview of operation
// - 32-bit registers, reset to zero
// - index 1 needs six or more priority bits
// - indices 2,3 need seven priority bits
// - unimplemented index raises undefined instruction, except group1 at secure EL1 under 64-bit monitor
// - all zeros means nothing active
// - fiq route steers NS EL1 group0 virtual
// - irq route steers NS EL1 group1 virtual
// - physical group0 at NS EL1 only unrouted
// - secure group1 from secure EL3, or secure EL1 under 64-bit monitor; else nonsecure
// - cp group12 trap sends NS EL1 to hypervisor
// - trap-all-group0 sends NS EL1 to EL2
// - trap-all-group1 sends NS EL1 to EL2
// - 64-bit monitor fiq route traps group0 to EL3
// - 64-bit monitor irq route traps group1 to EL3
// - interface enable off makes EL1 undefined
// - 32-bit monitor route makes non-monitor undefined
// - index in opc2 low bits; group0 CRm 8
// - group1 uses CRm 9 with prefix zero
`include "apr_map.vh"
module apr_regs (
	input wire mclk_i,
	input wire resetn_i,
	input wire acc_valid_i,
	input wire acc_write_i,
	input wire [2:0] acc_opc1_i,
	input wire [3:0] acc_crn_i,
	input wire [3:0] acc_crm_i,
	input wire [2:0] acc_opc2_i,
	input wire [31:0] acc_wdata_i,
	input wire [1:0] cur_el_i,
	input wire cur_nonsecure_i,
	input wire cur_monitor_mode_i,
	input wire [2:0] pri_bits_i,
	input wire hyp_fiq_route_i,
	input wire hyp_irq_route_i,
	input wire hyp_trap_cp_group12_i,
	input wire trap_all_group0_i,
	input wire trap_all_group1_i,
	input wire monitor_fiq_route_i,
	input wire monitor_irq_route_i,
	input wire monitor_is_64bit_i,
	input wire sysreg_interface_enable_i,
	output reg acc_done_o,
	output reg [2:0] acc_result_o,
	output reg [31:0] acc_rdata_o,
	output reg virt_valid_o,
	output reg virt_write_o,
	output reg virt_group1_o,
	output reg [1:0] virt_idx_o,
	output reg [31:0] virt_wdata_o,
	output wire group0_none_active_o,
	output wire group1s_none_active_o,
	output wire group1ns_none_active_o
);
	// index implemented for the configured priority width
	function idx_ok;
		input [1:0] idx;
		input [2:0] pb;
		begin
			case (idx)
				2'h0: idx_ok = 1'b1;
				2'h1: idx_ok = (pb >= `APR_PRI_IDX1);
				default: idx_ok = (pb >= `APR_PRI_IDX2);
			endcase
		end
	endfunction

	wire enc_base = (acc_crn_i == `APR_CRN_VAL) && (acc_opc1_i == `APR_OPC1_VAL);
	// group and index from CRm and opc2
	wire hit_g0 = enc_base && (acc_crm_i == `APR_CRM_G0) &&
		(acc_opc2_i[`APR_OP2_PFX_BIT] == `APR_OP2_G0_PFX);
	wire hit_g1 = enc_base && (acc_crm_i == `APR_CRM_G1) &&
		(acc_opc2_i[`APR_OP2_PFX_BIT] == `APR_OP2_G1_PFX);
	wire [1:0] idx = acc_opc2_i[1:0];
	wire ns_el1 = cur_nonsecure_i && (cur_el_i == `APR_EL1);
	wire s_el1 = !cur_nonsecure_i && (cur_el_i == `APR_EL1);
	wire at_el2 = (cur_el_i == `APR_EL2);
	wire at_el3 = (cur_el_i == `APR_EL3);
	wire route = hit_g0 ? hyp_fiq_route_i : hyp_irq_route_i;
	wire mon_route = hit_g0 ? monitor_fiq_route_i : monitor_irq_route_i;
	wire tall = hit_g0 ? trap_all_group0_i : trap_all_group1_i;

	reg [2:0] res;
	// priority: undefined, hypervisor traps, monitor traps, redirect, secure group1/index undefined, done
	always @* begin
		res = `APR_RES_OK;
		if (cur_el_i == `APR_EL0) begin
			res = `APR_RES_UNDEF;
		end else if ((cur_el_i == `APR_EL1) && !sysreg_interface_enable_i) begin
			res = `APR_RES_UNDEF;
		end else if (!monitor_is_64bit_i && mon_route &&
			(at_el2 || (at_el3 && !cur_monitor_mode_i) || (ns_el1 && !route))) begin
			res = `APR_RES_UNDEF;
		end else if (ns_el1 && hyp_trap_cp_group12_i) begin
			res = `APR_RES_TRAP_EL2;
		end else if (ns_el1 && tall) begin
			res = `APR_RES_TRAP_EL2;
		end else if (monitor_is_64bit_i && mon_route &&
			(s_el1 || at_el2 || (ns_el1 && !route))) begin
			res = `APR_RES_TRAP_EL3;
		end else if (ns_el1 && route) begin
			res = `APR_RES_VIRT;
		end else if (hit_g1 && s_el1) begin
			// secure group1 copy is EL3-only in a 32-bit monitor world
			res = monitor_is_64bit_i ? `APR_RES_OK : `APR_RES_UNDEF;
		end else if (!idx_ok(idx, pri_bits_i)) begin
			res = `APR_RES_UNDEF;
		end
	end

	// secure copy only from secure EL3 (or secure EL1 under 64-bit monitor)
	wire use_s = hit_g1 && !cur_nonsecure_i && (at_el3 || s_el1);
	wire hit = acc_valid_i && (hit_g0 || hit_g1);
	wire commit = hit && acc_write_i && (res == `APR_RES_OK);
	wire [31:0] rd_g0;
	wire [31:0] rd_s;
	wire [31:0] rd_ns;

	apr_bank u_g0 (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.wr_i(commit && hit_g0),
		.idx_i(idx),
		.wdata_i(acc_wdata_i),
		.rdata_o(rd_g0)
	);
	apr_bank u_g1s (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.wr_i(commit && use_s),
		.idx_i(idx),
		.wdata_i(acc_wdata_i),
		.rdata_o(rd_s)
	);
	apr_bank u_g1ns (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.wr_i(commit && hit_g1 && !use_s),
		.idx_i(idx),
		.wdata_i(acc_wdata_i),
		.rdata_o(rd_ns)
	);

	wire [31:0] rd_sel = hit_g0 ? rd_g0 : (use_s ? rd_s : rd_ns);

	// answer one cycle after the request; data only on permitted reads
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			acc_done_o <= 1'b0;
			acc_result_o <= `APR_RES_OK;
			acc_rdata_o <= 32'h00000000;
			virt_valid_o <= 1'b0;
			virt_write_o <= 1'b0;
			virt_group1_o <= 1'b0;
			virt_idx_o <= 2'h0;
			virt_wdata_o <= 32'h00000000;
		end else begin
			acc_done_o <= hit;
			acc_result_o <= hit ? res : `APR_RES_OK;
			acc_rdata_o <= (hit && !acc_write_i && res == `APR_RES_OK) ?
				rd_sel : 32'h00000000;
			virt_valid_o <= hit && (res == `APR_RES_VIRT);
			if (hit && (res == `APR_RES_VIRT)) begin
				virt_write_o <= acc_write_i;
				virt_group1_o <= hit_g1;
				virt_idx_o <= idx;
				virt_wdata_o <= acc_wdata_i;
			end
		end
	end

	// zero word at the opc2 index, or the other group's CRm/opc2 encoding on the bus, flags no active priorities; software keeps the write discipline
	assign group0_none_active_o = (rd_g0 == 32'h00000000) || hit_g1;
	assign group1s_none_active_o = (rd_s == 32'h00000000) || hit_g0;
	assign group1ns_none_active_o = (rd_ns == 32'h00000000) || hit_g0;
endmodule

// file: sim/apr_core.sv
module apr_core (
	input wire mclk_i,
	output logic valid_o,
	output logic write_o,
	output logic [3:0] crm_o,
	output logic [2:0] opc2_o,
	output logic [31:0] wdata_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle at time zero
	initial begin
		valid_o = 1'h0;
		write_o = 1'h0;
		crm_o = 4'h8;
		opc2_o = 3'h4;
		wdata_o = 32'h0;
	end
	// op = {write, group1, index}; taken at the single edge after the drive
	task acc(input logic [3:0] op, input logic [31:0] d);
		@(posedge mclk_i);
		#1;
		valid_o = 1'h1;
		write_o = op[3];
		crm_o = {3'h4, op[2]};
		opc2_o = {!op[2], op[1:0]};
		wdata_o = d;
		@(posedge mclk_i);
		#1;
		valid_o = 1'h0;
		wdata_o = ~d; // stale data must not look held
	endtask
endmodule

// file: sim/apr_regs_asserts.sv
module apr_regs_asserts (
	input wire mclk_i,
	input wire resetn_i,
	input wire acc_valid_i,
	input wire [2:0] acc_opc1_i,
	input wire [3:0] acc_crn_i,
	input wire [3:0] acc_crm_i,
	input wire [2:0] acc_opc2_i,
	input wire [1:0] cur_el_i,
	input wire [2:0] pri_bits_i,
	input wire sysreg_interface_enable_i,
	input wire acc_done_o,
	input wire [2:0] acc_result_o,
	input wire [31:0] acc_rdata_o,
	input wire virt_valid_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// crm must match the opc2 prefix, or the access is not ours
	wire hit = acc_valid_i && acc_opc1_i == 3'h0 && acc_crn_i == 4'hC
		&& acc_crm_i == {3'h4, !acc_opc2_i[2]};
	wire el1 = cur_el_i == 2'h1;
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);
	a_answer_next: assert property (hit |=> acc_done_o)
		else $error("no answer");
	a_miss_quiet: assert property (!hit |=> !acc_done_o)
		else $error("stray answer");
	a_off_undef: assert property (hit && el1 && !sysreg_interface_enable_i |=> acc_result_o == 3'h4)
		else $error("enable off passed");
	a_idx1_gate: assert property (hit && acc_opc2_i[1:0] != 2'h0 && pri_bits_i < 3'h6
		|=> acc_result_o != 3'h0)
		else $error("index one passed");
	a_idx23_gate: assert property (hit && acc_opc2_i[1] && pri_bits_i < 3'h7
		|=> acc_result_o != 3'h0)
		else $error("index two passed");
	a_refuse_zero: assert property (acc_done_o && acc_result_o > 3'h1 |-> acc_rdata_o == 32'h0)
		else $error("refused data");
	a_virt_tie: assert property (virt_valid_o |-> acc_done_o && acc_result_o == 3'h1)
		else $error("virt without answer");
	a_idle_zero: assert property (!acc_done_o |-> acc_result_o == 3'h0 && acc_rdata_o == 32'h0)
		else $error("idle not zero");
	// main outcomes seen
	c_virt: cover property (acc_done_o && acc_result_o == 3'h1);
	c_trap3: cover property (acc_done_o && acc_result_o == 3'h3);
	c_undef: cover property (acc_done_o && acc_result_o == 3'h4);
endmodule
bind apr_regs apr_regs_asserts apr_regs_asserts_i (.*);

// file: sim/apr_regs_tb.sv
module apr_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk_i = 1'h0;
	logic resetn_i = 1'h0;
	logic [15:0] st = 16'hA01F;
	logic v, w, dn, n0, n1s, n1n, vv, vw, vg;
	logic [1:0] vi;
	logic [31:0] vd;
	logic [3:0] crm;
	logic [2:0] op2, rs;
	logic [31:0] wd, rd;
	int err_total = 0;
	int total_checks = 0;
	initial forever #2 mclk_i = ~mclk_i;
	apr_core apr_core_i (.mclk_i(mclk_i), .valid_o(v), .write_o(w), .crm_o(crm), .opc2_o(op2),
		.wdata_o(wd));
	// state bits: el, ns, monitor, hf, hi, cp12, tall0, tall1, mf, mi, 64bit, enable, pri
	apr_regs apr_regs_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .acc_valid_i(v), .acc_write_i(w),
		.acc_opc1_i(3'h0), .acc_crn_i(4'hC), .acc_crm_i(crm), .acc_opc2_i(op2), .acc_wdata_i(wd),
		.cur_el_i(st[15:14]), .cur_nonsecure_i(st[13]), .cur_monitor_mode_i(st[12]),
		.hyp_fiq_route_i(st[11]), .hyp_irq_route_i(st[10]), .hyp_trap_cp_group12_i(st[9]),
		.trap_all_group0_i(st[8]), .trap_all_group1_i(st[7]), .monitor_fiq_route_i(st[6]),
		.monitor_irq_route_i(st[5]), .monitor_is_64bit_i(st[4]),
		.sysreg_interface_enable_i(st[3]), .pri_bits_i(st[2:0]), .acc_done_o(dn),
		.acc_result_o(rs), .acc_rdata_o(rd), .virt_valid_o(vv), .virt_write_o(vw),
		.virt_group1_o(vg), .virt_idx_o(vi), .virt_wdata_o(vd), .group0_none_active_o(n0),
		.group1s_none_active_o(n1s), .group1ns_none_active_o(n1n));
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask
	// refused accesses and writes return no data
	task ck(input logic [15:0] s, input logic [3:0] op, input logic [2:0] er, input logic [31:0] x);
		st = s;
		apr_core_i.acc(op, x);
		cmp({28'h0, dn, rs}, {29'h1, er});
		cmp(rd, (op[3] || er != 3'h0) ? 32'h0 : x);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard, far above the run length
	initial begin
		#30000;
		err_total++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge mclk_i);
		#1;
		resetn_i = 1'h1;
		for (int k = 0; k < 8; k++)
			ck(16'hA01F, k[3:0], 3'h0, 32'h0);
		$display("reset test done");
		ck(16'hA01F, 4'hB, 3'h0, 32'hA5A50F0F);
		ck(16'hD01F, 4'hC, 3'h0, 32'h12345678);
		ck(16'hA01F, 4'hC, 3'h0, 32'hFFFFFFFF);
		ck(16'h611F, 4'hB, 3'h2, 32'h0);
		ck(16'h601F, 4'h3, 3'h0, 32'hA5A50F0F);
		ck(16'hD01F, 4'h4, 3'h0, 32'h12345678);
		ck(16'h601F, 4'h4, 3'h0, 32'hFFFFFFFF);
		cmp({29'h0, n0, n1s, n1n}, 32'h4);
		ck(16'hA01F, 4'h8, 3'h0, 32'h1);
		cmp({31'h0, n0}, 32'h0);
		ck(16'hA01F, 4'h8, 3'h0, 32'h0);
		cmp({31'h0, n0}, 32'h1);
		$display("save restore test done");
		ck(16'hA01D, 4'h1, 3'h4, 32'h0);
		ck(16'hA01E, 4'h5, 3'h0, 32'h0);
		ck(16'hA01E, 4'h6, 3'h4, 32'h0);
		ck(16'hA01F, 4'h7, 3'h0, 32'h0);
		ck(16'h621F, 4'h0, 3'h2, 32'h0);
		ck(16'h609F, 4'h4, 3'h2, 32'h0);
		ck(16'hA05F, 4'h0, 3'h3, 32'h0);
		ck(16'h403F, 4'h4, 3'h3, 32'h0);
		ck(16'h6017, 4'h0, 3'h4, 32'h0);
		ck(16'hA04F, 4'h0, 3'h4, 32'h0);
		ck(16'h681F, 4'hA, 3'h1, 32'h0BADF00D);
		cmp({27'h0, vv, vw, vg, vi}, 32'h1A);
		cmp(vd, 32'h0BADF00D);
		ck(16'hA01F, 4'h2, 3'h0, 32'h0);
		ck(16'h641F, 4'h4, 3'h1, 32'h0);
		cmp({27'h0, vv, vw, vg, vi}, 32'h14);
		$display("trap test done");
		stop_test();
	end
endmodule
